// ### wdg_pkg.sv
package wdg_pkg;

  localparam int unsigned CLOCK_MHZ          = 250;
  localparam int unsigned DEC_PERIOD_CYCLES  = 3072;
  localparam int unsigned TIMEOUT_STEPS      = 64;
  localparam int unsigned RESET_PULSE_NS     = 500;
  localparam int unsigned RESET_PULSE_CYCLES = (RESET_PULSE_NS * CLOCK_MHZ + 999) / 1000;

  localparam int unsigned COUNT_W  = 7;
  localparam int unsigned EVT_W    = 3;

  // watchdog_count_register layout
  localparam int unsigned ACT_POS  = 0;
  localparam int unsigned SR_POS   = 1;
  localparam int unsigned T_LO_POS = 2;
  localparam int unsigned T_HI_POS = 7;
  localparam logic [7:0]  WDG_RESET_VALUE = 8'hFE;

  // register byte offsets
  localparam logic [7:0] OFS_WDG    = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_STATE  = 8'h0C;

  // status and mask bit positions
  localparam int unsigned EVT_TIMEOUT = 0;
  localparam int unsigned EVT_SOFT    = 1;
  localparam int unsigned EVT_WRAP    = 2;
  localparam logic [EVT_W-1:0] STATUS_RESET_VALUE = 3'h0;
  localparam logic [EVT_W-1:0] MASK_RESET_VALUE   = 3'h0;

  // state readout bit positions
  localparam int unsigned ST_HW_OPT  = 0;
  localparam int unsigned ST_EXT_OPT = 1;
  localparam int unsigned ST_ACTIVE  = 2;
  localparam int unsigned ST_WAIT    = 3;
  localparam int unsigned ST_STOP    = 4;
  localparam int unsigned ST_NMI     = 5;

  typedef enum logic [1:0]
  {
    PM_RUN  = 2'b00,
    PM_WAIT = 2'b01,
    PM_STOP = 2'b10
  } pm_t;

  typedef struct packed
  {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } ahb_req_t;

  typedef struct packed
  {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } ahb_rsp_t;

  function automatic logic [5:0] rev6(input logic [5:0] v);
    rev6 = {v[0], v[1], v[2], v[3], v[4], v[5]};
  endfunction

endpackage

// ### wdg_prescaler.sv
`timescale 1ns/1ns
module wdg_prescaler
#(
  parameter int unsigned DIV = wdg_pkg::DEC_PERIOD_CYCLES
)
(
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_run,
  output logic      o_tick
);
  import wdg_pkg::*;

  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed
  {
    logic [CW-1:0] cnt;
    logic          tick;
  } pre_t;

  pre_t s_reg;
  pre_t s_next;

  // halted while frozen, so a stop resumes mid-period
  always_comb
  begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (i_run)
    begin
      if (s_reg.cnt == LAST)
      begin
        s_next.cnt  = '0;
        s_next.tick = 1'b1;
      end
      else
      begin
        s_next.cnt = s_reg.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign o_tick = s_reg.tick;

  a_tick_single : assert property (@(posedge i_clock) disable iff (i_rst)
    s_reg.tick |=> !s_reg.tick)
    else $error("prescaler tick longer than one cycle");

endmodule

// ### wdg_reset_pulse.sv
`timescale 1ns/1ns
module wdg_reset_pulse
#(
  parameter int unsigned LEN = wdg_pkg::RESET_PULSE_CYCLES
)
(
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_fire,
  output logic      o_reset_n
);
  import wdg_pkg::*;

  localparam int unsigned CW = $clog2(LEN + 1);

  typedef struct packed
  {
    logic [CW-1:0] left;
    logic          pin_n;
  } pulse_t;

  pulse_t s_reg;
  pulse_t s_next;
  logic [CW-1:0] low_cnt;

  always_comb
  begin
    s_next = s_reg;
    if (s_reg.left != '0)
    begin
      s_next.left = s_reg.left - CW'(1);
      if (s_reg.left == CW'(1))
        s_next.pin_n = 1'b1;
    end
    else if (i_fire)
    begin
      s_next.left  = CW'(LEN);
      s_next.pin_n = 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      s_reg <= '{left: '0, pin_n: 1'b1};
    else
      s_reg <= s_next;
  end

  assign o_reset_n = s_reg.pin_n;

  // helper: length of the low pulse
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      low_cnt <= '0;
    else if (!s_reg.pin_n)
      low_cnt <= low_cnt + CW'(1);
    else
      low_cnt <= '0;
  end

  a_pulse_length : assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(s_reg.pin_n) |-> low_cnt == CW'(LEN))
    else $error("reset pulse length wrong");

endmodule

// ### mcu_watchdog_timer.sv
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ns
module mcu_watchdog_timer
(
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire wdg_pkg::ahb_req_t i_ahb,
  input  wire logic              i_activation_option_bit,
  input  wire logic              i_external_stop_option_bit,
  input  wire logic              i_nmi,
  input  wire logic              i_stop_request,
  input  wire logic              i_wakeup,
  output wdg_pkg::ahb_rsp_t      o_ahb,
  output logic                   o_reset_n,
  output logic                   o_wait_mode,
  output logic                   o_stop_mode,
  output logic                   o_irq
);
  import wdg_pkg::*;

  typedef struct packed
  {
    logic [1:0]         opt_s1;
    logic [1:0]         opt_s2;
    logic               nmi_s1;
    logic               nmi_s2;
    logic               c_bit;
    logic [COUNT_W-1:0] count;
    logic               wr_pend;
    logic [7:0]         wr_addr;
    logic [EVT_W-1:0]   status;
    logic [EVT_W-1:0]   mask;
    pm_t                pm;
    logic               fire;
    logic               irq;
    logic [31:0]        hrdata;
  } wdg_state_t;

  localparam logic [COUNT_W-1:0] COUNT_RESET =
    {WDG_RESET_VALUE[SR_POS], rev6(WDG_RESET_VALUE[T_HI_POS:T_LO_POS])};

  wdg_state_t s_reg;
  wdg_state_t s_next;

  logic tick;
  logic busy;
  logic hw_opt;
  logic ext_opt;
  logic active;
  logic active_next;
  logic take;
  logic wr_wdg;
  logic [7:0] wdata;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;

  function automatic logic [7:0] wdg_view(input logic [COUNT_W-1:0] cnt, input logic act);
    wdg_view = {rev6(cnt[5:0]), cnt[6], act};
  endfunction

  function automatic logic [31:0] read_mux(input wdg_state_t st, input logic [7:0] a,
                                           input logic act);
    read_mux = 32'h0000_0000;
    if (a == OFS_WDG)
      read_mux[7:0] = wdg_view(st.count, act);
    else if (a == OFS_STATUS)
      read_mux[EVT_W-1:0] = st.status;
    else if (a == OFS_MASK)
      read_mux[EVT_W-1:0] = st.mask;
    else if (a == OFS_STATE)
    begin
      read_mux[ST_HW_OPT]  = st.opt_s2[0];
      read_mux[ST_EXT_OPT] = st.opt_s2[1];
      read_mux[ST_ACTIVE]  = act;
      read_mux[ST_WAIT]    = st.pm == PM_WAIT;
      read_mux[ST_STOP]    = st.pm == PM_STOP;
      read_mux[ST_NMI]     = st.nmi_s2;
    end
  endfunction

  wdg_prescaler
  #(
    .DIV (DEC_PERIOD_CYCLES)
  )
  u_prescaler
  (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_run   ((s_reg.pm != PM_STOP) && !busy),
    .o_tick  (tick)
  );

  wdg_reset_pulse
  #(
    .LEN (RESET_PULSE_CYCLES)
  )
  u_reset_pulse
  (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_fire    (s_reg.fire),
    .o_reset_n (o_reset_n)
  );

  assign busy = !o_reset_n;

  always_comb
  begin
    s_next        = s_reg;
    s_next.opt_s1 = {i_external_stop_option_bit, i_activation_option_bit};
    s_next.opt_s2 = s_reg.opt_s1;
    s_next.nmi_s1 = i_nmi;
    s_next.nmi_s2 = s_reg.nmi_s1;
    s_next.fire   = 1'b0;
    hw_opt        = s_reg.opt_s2[0];
    ext_opt       = s_reg.opt_s2[1];
    active        = s_reg.c_bit | hw_opt;
    evt_set       = '0;
    evt_clr       = '0;

    // bus address phase
    take           = i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready;
    s_next.wr_pend = take && i_ahb.hwrite;
    s_next.wr_addr = i_ahb.haddr[7:0];
    wdata          = i_ahb.hwdata[7:0];
    wr_wdg         = s_reg.wr_pend && (s_reg.wr_addr == OFS_WDG);

    // counter, frozen in stop and during the reset pulse
    if (tick && s_reg.pm != PM_STOP && !busy)
    begin
      s_next.count = s_reg.count - 7'h01;
      if (!active && s_reg.count == 7'h00)
        evt_set[EVT_WRAP] = 1'b1;
    end

    // data phase writes win over the decrement
    if (wr_wdg)
    begin
      s_next.count = {wdata[SR_POS], rev6(wdata[T_HI_POS:T_LO_POS])};
      if (wdata[ACT_POS])
        s_next.c_bit = 1'b1;
    end
    else if (s_reg.wr_pend && s_reg.wr_addr == OFS_STATUS)
    begin
      evt_clr = wdata[EVT_W-1:0];
    end
    else if (s_reg.wr_pend && s_reg.wr_addr == OFS_MASK)
    begin
      s_next.mask = wdata[EVT_W-1:0];
    end

    // expiry or software reset once armed
    active_next = s_next.c_bit | hw_opt;
    if (active_next && !s_next.count[6] && !busy)
    begin
      s_next.fire  = 1'b1;
      s_next.count = COUNT_RESET;
      s_next.c_bit = 1'b0;
      s_next.pm    = PM_RUN;
      if (wr_wdg)
        evt_set[EVT_SOFT] = 1'b1;
      else
        evt_set[EVT_TIMEOUT] = 1'b1;
    end
    else if (i_wakeup)
    begin
      s_next.pm = PM_RUN;
    end
    else if (i_stop_request && s_reg.pm == PM_RUN)
    begin
      if (!active)
        s_next.pm = PM_STOP;
      else if (ext_opt && s_reg.nmi_s2)
        s_next.pm = PM_STOP;
      else
        s_next.pm = PM_WAIT;
    end

    // set wins over a write-one clear
    s_next.status = (s_reg.status & ~evt_clr) | evt_set;
    s_next.irq    = |(s_next.status & s_next.mask);
    // read data from next values so a write just before shows up
    s_next.hrdata = read_mux(s_next, i_ahb.haddr[7:0], active_next);
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_reg         <= '0;
      s_reg.count   <= COUNT_RESET;
      s_reg.c_bit   <= WDG_RESET_VALUE[ACT_POS];
      s_reg.status  <= STATUS_RESET_VALUE;
      s_reg.mask    <= MASK_RESET_VALUE;
      s_reg.pm      <= PM_RUN;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_ahb.hreadyout = 1'b1;
  assign o_ahb.hresp     = 1'b0;
  assign o_ahb.hrdata    = s_reg.hrdata;
  assign o_wait_mode     = s_reg.pm[0];
  assign o_stop_mode     = s_reg.pm[1];
  assign o_irq           = s_reg.irq;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  // checked through the read path, not the internal flag
  a_hw_forced_on : assert property (
    hw_opt && i_ahb.haddr[7:0] == OFS_WDG |=> s_reg.hrdata[ACT_POS])
    else $error("hardware option left watchdog inactive");

  a_sw_arm_sticky : assert property (
    s_reg.c_bit && !s_next.fire |=> s_reg.c_bit)
    else $error("activate bit dropped without reset");

  a_decrement_step : assert property (
    tick && s_reg.pm != PM_STOP && !busy && !s_reg.wr_pend && !s_next.fire
    |=> s_reg.count == $past(s_reg.count) - 7'h01)
    else $error("counter did not step down on tick");

  a_hold_idle : assert property (
    !tick && !s_reg.wr_pend && !s_next.fire |=> $stable(s_reg.count))
    else $error("counter moved without tick");

  a_write_loads : assert property (
    wr_wdg && !s_next.fire
    |=> s_reg.count == {$past(wdata[SR_POS]), rev6($past(wdata[T_HI_POS:T_LO_POS]))})
    else $error("write did not load counter");

  // last step from 40h clears the soft-reset bit: fire, then pin low
  a_expiry_reset : assert property (
    active && tick && s_reg.pm != PM_STOP && s_reg.count == 7'h40 && !busy
    && !s_reg.wr_pend |-> ##2 !o_reset_n)
    else $error("expired watchdog did not reset");

  a_timeout_flag : assert property (
    active && tick && s_reg.pm != PM_STOP && s_reg.count == 7'h40 && !busy
    && !s_reg.wr_pend |=> s_reg.status[EVT_TIMEOUT])
    else $error("timeout event not flagged");

  a_busy_frozen : assert property (
    busy && !s_reg.wr_pend |=> $stable(s_reg.count))
    else $error("counter moved during reset pulse");

  a_fire_reload : assert property (
    s_reg.fire |-> s_reg.count == COUNT_RESET && !s_reg.c_bit)
    else $error("counter not restored after firing");

  a_wait_counts : assert property (
    s_reg.pm == PM_WAIT && tick && !busy && !s_reg.wr_pend && !s_next.fire
    |=> s_reg.count == $past(s_reg.count) - 7'h01)
    else $error("counter not running in wait");

  a_stop_entry : assert property (
    i_stop_request && s_reg.pm == PM_RUN && !active && !s_next.fire && !i_wakeup
    |=> s_reg.pm == PM_STOP)
    else $error("unarmed stop not entered");

  a_arm_by_write : assert property (
    wr_wdg && wdata[ACT_POS] && wdata[SR_POS] |=> s_reg.c_bit)
    else $error("write did not arm watchdog");

  // an unarmed timer must never pull the reset pin
  a_unarmed_quiet : assert property (
    !s_reg.c_bit && !hw_opt && !wr_wdg |=> !s_reg.fire)
    else $error("unarmed timer fired a reset");

  a_soft_flag : assert property (
    wr_wdg && !wdata[SR_POS] && active && !busy |=> s_reg.status[EVT_SOFT])
    else $error("software reset event not flagged");

  a_soft_reset : assert property (
    wr_wdg && !wdata[SR_POS] && (wdata[ACT_POS] || active) && !busy
    |=> s_reg.fire ##1 !o_reset_n)
    else $error("software reset not taken");

  a_timer_wraps : assert property (
    !active && !s_reg.c_bit && tick && s_reg.pm != PM_STOP && !busy
    && !s_reg.wr_pend && s_reg.count == 7'h00 |=> s_reg.count == 7'h7F)
    else $error("timer did not wrap");

  a_stop_freeze : assert property (
    s_reg.pm == PM_STOP && !s_reg.wr_pend |=> $stable(s_reg.count))
    else $error("counter moved in stop");

  a_stop_as_wait : assert property (
    i_stop_request && s_reg.pm == PM_RUN && active && !s_next.fire && !i_wakeup
    && !(ext_opt && s_reg.nmi_s2) |=> s_reg.pm == PM_WAIT)
    else $error("armed stop not taken as wait");

  a_irq_level : assert property (
    ##1 o_irq == |($past(s_next.status) & $past(s_next.mask)))
    else $error("interrupt output wrong");

  c_timeout_reset : cover property (
    !s_reg.wr_pend && s_reg.fire ##1 !o_reset_n);

  c_soft_reset : cover property (
    wr_wdg && !wdata[SR_POS] ##1 s_reg.fire);

  c_timer_wrap : cover property (
    s_next.status[EVT_WRAP] && !s_reg.status[EVT_WRAP]);

  c_frozen_stop : cover property (
    active && s_reg.pm == PM_STOP);

  c_stop_as_wait : cover property (
    active && s_reg.pm == PM_WAIT);

endmodule

// ### wdg_cpu_model.sv
`timescale 1ns/1ns
module wdg_cpu_model
  import wdg_pkg::*;
(
  input  wire logic              i_clock,
  input  wire wdg_pkg::ahb_rsp_t i_rsp,
  output wdg_pkg::ahb_req_t      o_req
);
  ahb_req_t req = '0;

  always_comb
  begin
    o_req        = req;
    o_req.hready = i_rsp.hreadyout;
  end

  function automatic logic [5:0] flip(input logic [5:0] t);
    flip = {t[0], t[1], t[2], t[3], t[4], t[5]};
  endfunction

  // address phase held until hready, data taken at the closing edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    req <= '{hsel: 1'h1, haddr: {24'h0, a}, htrans: 2'h2, hwrite: w,
             hsize: 3'h2, hready: 1'h1, hwdata: 32'h0};
    do @(posedge i_clock); while (i_rsp.hreadyout !== 1'h1);
    req.hsel   <= 1'h0;
    req.htrans <= 2'h0;
    req.hwdata <= {24'h0, d};
    do @(posedge i_clock); while (i_rsp.hreadyout !== 1'h1);
    q = i_rsp.hrdata[7:0];
  endtask

  // reload: armed, soft-reset bit kept set, t+1 decrements left
  task automatic kick(input logic [5:0] t);
    logic [7:0] q;
    xfer(1'h1, OFS_WDG, {flip(t), 2'h3}, q);
  endtask

  // timer user forces a reset if it finds the watchdog armed
  task automatic guard();
    logic [7:0] q;
    xfer(1'h0, OFS_WDG, 8'h00, q);
    if (q[ACT_POS] === 1'h1)
      xfer(1'h1, OFS_WDG, 8'hFD, q);
  endtask
endmodule

// ### test_mcu_watchdog_timer.sv
`timescale 1ns/1ns
module test_mcu_watchdog_timer;
  import wdg_pkg::*;
  logic       i_clock  = 1'h0;
  logic       i_rst    = 1'h1;
  logic       act_opt  = 1'h0;
  logic       ext_opt  = 1'h0;
  logic       nmi      = 1'h0;
  logic       stop_req = 1'h0;
  logic       wake     = 1'h0;
  ahb_req_t   req;
  ahb_rsp_t   rsp;
  logic       reset_n;
  logic       wait_m;
  logic       stop_m;
  logic       irq;
  logic [7:0] q;
  logic [7:0] p;
  logic [7:0] r;
  int         n;
  int         miscompares = 0;
  int         n_tests     = 0;

  always #2 i_clock = ~i_clock;

  mcu_watchdog_timer u_dut
  (
    .i_clock                    (i_clock),
    .i_rst                      (i_rst),
    .i_ahb                      (req),
    .i_activation_option_bit    (act_opt),
    .i_external_stop_option_bit (ext_opt),
    .i_nmi                      (nmi),
    .i_stop_request             (stop_req),
    .i_wakeup                   (wake),
    .o_ahb                      (rsp),
    .o_reset_n                  (reset_n),
    .o_wait_mode                (wait_m),
    .o_stop_mode                (stop_m),
    .o_irq                      (irq)
  );

  wdg_cpu_model u_cpu
  (
    .i_clock (i_clock),
    .i_rsp   (rsp),
    .o_req   (req)
  );

  // counter as {soft-reset, T5..T0}, T0 sits at bit 7
  function automatic logic [6:0] cnt(input logic [7:0] v);
    cnt = {v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
  endfunction

  task automatic stop_test();
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s exp %0h seen %0h", s, exp, seen);
    end
  endtask

  task automatic rd(input logic [7:0] a);
    u_cpu.xfer(1'h0, a, 8'h00, q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_cpu.xfer(1'h1, a, d, p);
  endtask

  task automatic do_reset(input logic hw, input logic ext);
    i_rst   <= 1'h1;
    act_opt <= hw;
    ext_opt <= ext;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'h0;
    repeat (3) @(posedge i_clock);
  endtask

  task automatic pulse(input logic to_stop);
    if (to_stop)
      stop_req <= 1'h1;
    else
      wake <= 1'h1;
    @(posedge i_clock);
    stop_req <= 1'h0;
    wake     <= 1'h0;
    repeat (3) @(posedge i_clock);
  endtask

  // reset pin must fall within lo..hi cycles, then interrupt raise/mask/clear
  task automatic fire(input string s, input int lo, input int hi, input int ev);
    n = 0;
    while (reset_n !== 1'h0 && n < hi)
    begin
      @(negedge i_clock);
      n++;
    end
    check(s, (n >= lo && n < hi), 1);
    n = 0;
    while (reset_n === 1'h0 && n < 300)
    begin
      @(negedge i_clock);
      n++;
    end
    check("pulse_len", n, RESET_PULSE_CYCLES);
    @(posedge i_clock);
    rd(OFS_STATUS);
    check("event", q[ev], 1'h1);
    check("irq_masked", irq, 1'h0);
    wr(OFS_MASK, 8'h01 << ev);
    repeat (2) @(posedge i_clock);
    check("irq_on", irq, 1'h1);
    wr(OFS_STATUS, 8'h01 << ev);
    repeat (2) @(posedge i_clock);
    check("irq_off", irq, 1'h0);
    wr(OFS_MASK, 8'h00);
  endtask

  initial
  begin
    repeat (40000) @(posedge i_clock);
    miscompares++;
    stop_test();
  end

  initial
  begin
    void'($urandom(72599));
    do_reset(1'h0, 1'h0);
    check("rst_pin", reset_n, 1'h1);
    rd(OFS_WDG);
    check("wdg_rst", q, WDG_RESET_VALUE);
    rd(OFS_STATUS);
    check("status_rst", q, 8'h00);
    rd(8'h10);
    check("unmapped", q, 8'h00);
    // unarmed timer: load a random value, then one step per decrement period
    repeat (4)
    begin
      r = 8'($urandom()) & 8'hFE;
      wr(OFS_WDG, r);
      rd(OFS_WDG);
      check("load", cnt(q), cnt(r));
      r = q;
      repeat (DEC_PERIOD_CYCLES - 2) @(posedge i_clock);
      rd(OFS_WDG);
      check("dec", cnt(q), 7'(cnt(r) - 7'h01));
    end
    wr(OFS_STATUS, 8'h07);
    wr(OFS_WDG, 8'h01);
    fire("soft_reset", 0, 4, EVT_SOFT);
    rd(OFS_WDG);
    check("after_fire", q, WDG_RESET_VALUE);
    // armed with two steps; a write of C=0 cannot disarm
    u_cpu.kick(6'h01);
    wr(OFS_WDG, 8'h82);
    rd(OFS_WDG);
    check("stay_armed", q, 8'h83);
    fire("timeout", DEC_PERIOD_CYCLES - 8, 2 * DEC_PERIOD_CYCLES + 4, EVT_TIMEOUT);
    // hardware option with external stop control
    do_reset(1'h1, 1'h1);
    rd(OFS_WDG);
    check("hw_act", q[ACT_POS], 1'h1);
    wr(OFS_WDG, 8'hFE);
    rd(OFS_WDG);
    check("hw_locked", q[ACT_POS], 1'h1);
    u_cpu.kick(6'h3F);
    pulse(1'h1);
    check("as_wait", {wait_m, stop_m}, 2'h2);
    pulse(1'h0);
    check("woke", wait_m, 1'h0);
    nmi <= 1'h1;
    repeat (4) @(posedge i_clock);
    pulse(1'h1);
    check("stopped", {wait_m, stop_m}, 2'h1);
    rd(OFS_WDG);
    r = q;
    repeat (DEC_PERIOD_CYCLES - 2) @(posedge i_clock);
    rd(OFS_WDG);
    check("frozen", q, r);
    pulse(1'h0);
    check("stop_left", stop_m, 1'h0);
    nmi <= 1'h0;
    u_cpu.guard();
    fire("guard_reset", 0, 4, EVT_SOFT);
    stop_test();
  end
endmodule
